// *** verilog/tao_top.sv ***
// Digital output side of a three-channel 8-bit pipelined converter
`timescale 1ns/1ps
`include "tao_cfg.svh"

// Function
// R1 - Format select low gives offset binary: zeros negative, ones positive full scale.
// R2 - Format select high inverts only the most significant bit.
// R3 - Out-of-range results clip to the full-scale code of the chosen format.
// R4 - Samples are taken on the falling clock edge, lagged by sampling delay.
// R5 - Output bus changes after rising edge; capture waits output valid delay.
// R6 - A sample's word appears on the bus seven clock cycles after sampling.
// R7 - After the latency, one new word per channel every cycle, no gaps.
// R8 - Controlling logic runs init cycles after power-up, treats data as invalid.
// R9 - At most twenty init cycles; capture discards the first twenty words.
// R10 - Clock source keeps fifty percent duty within five percent, above 1 MSPS.
// R11 - All three channels share the clock and update together, same latency.
module tao_top import tao_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Format select pin
	input wire logic format_select,
	// Raw quantiser results, signed 10 bit so that overrange is visible
	input wire logic signed [9:0] raw_red,
	input wire logic signed [9:0] raw_green,
	input wire logic signed [9:0] raw_blue,
	// Output data buses
	output logic [7:0] red_data,
	output logic [7:0] green_data,
	output logic [7:0] blue_data,
	output logic data_valid,
	output logic clk_out,
	// Receiver stall
	input wire logic recv_ready
);
	typedef struct packed {
		logic [1:0] fmt_sync;
		tao_mode_t mode;
		logic [4:0] init_cnt;
		logic [`TAO_LAT-3:0] vld_pipe;
		logic [`TAO_LAT-3:0][23:0] dat_pipe;
		logic [23:0] out_bus;
		logic out_vld;
		logic clk_out;
	} tao_top_st_t;
	tao_top_st_t s_r, s_nxt;
	// Reset synchroniser kept apart: it is the only state on the raw reset
	logic [1:0] rst_sync_r;
	logic rst_n;
	// Falling-edge sample holds, one per channel
	logic [7:0] smp_red_r, smp_grn_r, smp_blu_r;
	logic [23:0] fmt_word;
	logic buf_in_ready, buf_out_valid;
	logic [23:0] buf_out_data;

	// Saturate a raw value to the 8-bit offset binary range
	function automatic tao_word_t tao_clip(input logic signed [9:0] raw);
		tao_word_t w;
		if (raw > `TAO_RAW_MAX) begin
			w = `TAO_POS_FS; // [R3]
		end else if (raw < `TAO_RAW_MIN) begin
			w = `TAO_NEG_FS; // [R3]
		end else begin
			w = raw[7:0]; // [R1]
		end
		return w;
	endfunction

	// Apply output format; two's complement is the top bit flipped
	function automatic tao_word_t tao_fmt(input tao_word_t w, input logic two_c);
		tao_word_t o;
		o = w;
		o[`TAO_MSB] = w[`TAO_MSB] ^ two_c; // [R2]
		return o;
	endfunction

	assign rst_n = rst_sync_r[1];

	// ***********************************************
	// Sampling on the falling edge
	// ***********************************************
	// Held at negedge so the pipeline sees a stable value; the analog
	// aperture lag itself is outside this digital model
	always_ff @(negedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			smp_red_r <= 8'h00;
			smp_grn_r <= 8'h00;
			smp_blu_r <= 8'h00;
		end else begin
			smp_red_r <= tao_clip(raw_red); // [R4]
			smp_grn_r <= tao_clip(raw_green); // [R4]
			smp_blu_r <= tao_clip(raw_blue); // [R4]
		end
	end

	// Format chosen as the word enters the pipe, all channels alike
	always_comb begin
		fmt_word = {tao_fmt(smp_red_r, s_r.fmt_sync[1]), tao_fmt(smp_grn_r, s_r.fmt_sync[1]),
			tao_fmt(smp_blu_r, s_r.fmt_sync[1])}; // [R11]
	end

	// ***********************************************
	// Pipeline and init tracking
	// ***********************************************
	// Rising edges after the falling-edge sample: five pipe stages, one
	// buffer slot and the output register make seven in all
	// The buffer slot and the output register cost an edge each, so the pipe is two short of the latency
	// A stall freezes the whole pipe once the buffer holds two words; samples taken meanwhile are dropped
	always_comb begin
		s_nxt = s_r;
		s_nxt.fmt_sync = {s_r.fmt_sync[0], format_select};
		s_nxt.clk_out = ~s_r.clk_out;
		if (buf_in_ready) begin
			s_nxt.dat_pipe = {s_r.dat_pipe[`TAO_LAT-4:0], fmt_word}; // [R6]
			s_nxt.vld_pipe = {s_r.vld_pipe[`TAO_LAT-4:0], 1'b1}; // [R7]
		end
		unique case (s_r.mode)
			TAO_INIT: begin
				s_nxt.init_cnt = s_r.init_cnt + 5'h01;
				if (s_r.init_cnt == 5'(`TAO_INIT_CYC - 1)) begin
					s_nxt.mode = TAO_RUN; // [R9]
				end
			end
			TAO_RUN: begin
				s_nxt.init_cnt = s_r.init_cnt;
			end
			default: begin
				s_nxt.mode = TAO_INIT;
			end
		endcase
		// Output register updated on rising edge from the buffer head
		if (recv_ready) begin
			s_nxt.out_bus = buf_out_data; // [R5] [R11]
			s_nxt.out_vld = buf_out_valid && (s_r.mode == TAO_RUN); // [R8]
		end
	end

	// Reset synchroniser runs on the raw reset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	// Remaining state on the synchronised reset
	// Mode resets to its one-hot init code, not to zero, so that the
	// init count starts on the first edge after release
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r.fmt_sync <= 2'b00;
			s_r.mode <= TAO_INIT;
			s_r.init_cnt <= 5'h00;
			s_r.vld_pipe <= '0;
			s_r.dat_pipe <= '0;
			s_r.out_bus <= 24'h000000;
			s_r.out_vld <= 1'b0;
			s_r.clk_out <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Buffer absorbs a receiver stall so no word already in the pipe is lost
	tao_skid u_skid (
		.clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(s_r.vld_pipe[`TAO_LAT-3]),
		.in_ready(buf_in_ready),
		.in_data(s_r.dat_pipe[`TAO_LAT-3]),
		.out_valid(buf_out_valid),
		.out_ready(recv_ready),
		.out_data(buf_out_data)
	);

	// Outputs straight from flip-flops
	assign red_data = s_r.out_bus[23:16];
	assign green_data = s_r.out_bus[15:8];
	assign blue_data = s_r.out_bus[7:0];
	assign data_valid = s_r.out_vld;
	assign clk_out = s_r.clk_out;

	// ***********************************************
	// Checks
	// ***********************************************
	// Nothing valid leaves while the dynamic circuits warm up
	a_init_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
		(s_r.mode == TAO_INIT) |-> ##1 !data_valid)
		else $error("valid during init");
	// Warm-up ends on the last counted cycle, never later
	a_init_len: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
		(s_r.mode == TAO_INIT && s_r.init_cnt == 5'(`TAO_INIT_CYC - 1))
		|=> (s_r.mode == TAO_RUN))
		else $error("init not ended after twenty cycles");
	// Once running, only a reset brings the warm-up back
	a_run_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
		(s_r.mode == TAO_RUN) |=> (s_r.mode == TAO_RUN))
		else $error("left run mode without reset");
	// Seven clean edges flush every stale stage, so the bus must carry
	// exactly the word formatted seven edges back
	a_lat_seven: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
		(buf_in_ready && recv_ready && s_r.vld_pipe == 5'h1f && buf_out_valid) [*7]
		|=> (s_r.out_bus == $past(fmt_word, 7)))
		else $error("latency not seven cycles");
	// A flowing stream keeps its valid level up
	a_no_gap: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
		(data_valid && recv_ready && buf_in_ready && s_r.vld_pipe[`TAO_LAT-3]) [*2]
		|=> data_valid)
		else $error("gap in output stream");
	// A stalled receiver sees the same word until it takes it
	a_stall_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
		!recv_ready |=> $stable(s_r.out_bus) && $stable(s_r.out_vld))
		else $error("output moved during stall");
	// Format logic touches the top bit only
	a_twos_msb: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
		s_r.fmt_sync[1]
		|-> (fmt_word[23] != smp_red_r[7]) && (fmt_word[22:16] == smp_red_r[6:0]))
		else $error("two's complement not msb flip");
	a_off_bin: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
		!s_r.fmt_sync[1] |-> fmt_word == {smp_red_r, smp_grn_r, smp_blu_r})
		else $error("offset binary altered");
	// Clipping seen at the sample holds, one falling edge later
	a_clip_hi: assert property (@(negedge sys_clk) disable iff (!rst_n) // [R3]
		(raw_red > `TAO_RAW_MAX) |=> smp_red_r == `TAO_POS_FS)
		else $error("positive clip failed");
	a_clip_lo: assert property (@(negedge sys_clk) disable iff (!rst_n) // [R3]
		(raw_green < `TAO_RAW_MIN) |=> smp_grn_r == `TAO_NEG_FS)
		else $error("negative clip failed");
	a_clip_blue: assert property (@(negedge sys_clk) disable iff (!rst_n) // [R3]
		(raw_blue > `TAO_RAW_MAX) |=> smp_blu_r == `TAO_POS_FS)
		else $error("blue positive clip failed");
endmodule

// *** inc/tao_cfg.svh ***
// Constants of the triple output pipeline: widths, latency, codes, init count
`ifndef TAO_CFG_SVH
`define TAO_CFG_SVH
`define TAO_DW 8
`define TAO_LAT 7
`define TAO_INIT_CYC 20
`define TAO_MSB 7
`define TAO_POS_FS 8'hff
`define TAO_NEG_FS 8'h00
`define TAO_RAW_MAX 10'sh0ff
`define TAO_RAW_MIN 10'sh000
`endif

// *** inc/tao_pkg.sv ***
// Types of the triple output pipeline
package tao_pkg;
	typedef logic [7:0] tao_word_t;
	typedef enum logic [1:0] {
		TAO_INIT = 2'b01,
		TAO_RUN = 2'b10
	} tao_mode_t;
endpackage

// *** verilog/tao_skid.sv ***
// Two-entry buffer carrying the three channel words as one 24-bit entry
`timescale 1ns/1ps
module tao_skid import tao_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [23:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [23:0] out_data
);
	typedef struct packed {
		logic [1:0] cnt;
		logic [23:0] e0;
		logic [23:0] e1;
	} tao_skid_st_t;
	tao_skid_st_t s_r, s_nxt;
	logic push, pop;

	// Handshakes; ready honest while one slot is free
	assign in_ready = (s_r.cnt != 2'h2);
	assign out_valid = (s_r.cnt != 2'h0);
	assign out_data = s_r.e0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next state: e0 is the head entry
	always_comb begin
		s_nxt = s_r;
		if (pop) begin
			s_nxt.e0 = s_r.e1;
		end
		if (push) begin
			if ((s_r.cnt == 2'h0) || (s_r.cnt == 2'h1 && pop)) begin
				s_nxt.e0 = in_data;
			end else begin
				s_nxt.e1 = in_data;
			end
		end
		s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Count never exceeds two entries
	a_skid_bound: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
		s_r.cnt <= 2'h2)
		else $error("buffer count above two");
endmodule

// *** sim/tao_cap.sv ***
// Capture model latching the three output buses of the pipeline
`timescale 1ns/1ps
module tao_cap (
	// Clock and stall control
	input wire logic clk,
	input wire logic stall_en,
	// Buses from the pipeline
	input wire logic [7:0] red_data,
	input wire logic [7:0] green_data,
	input wire logic [7:0] blue_data,
	input wire logic data_valid,
	// Capture results
	output logic recv_ready = 1'b1,
	output logic cap_new = 1'b0,
	output logic [23:0] cap_word = 24'h000000
);
	logic [1:0] ph_r = 2'h0;
	int n_seen = 0;
	// Latch at the next rising edge with ready high: a full cycle after the bus moved, four when stalled
	always @(posedge clk) begin
		ph_r <= ph_r + 2'h1;
		recv_ready <= !stall_en || (ph_r == 2'h3); // Slow receiver: one edge in four
		cap_new <= 1'b0;
		if (data_valid && recv_ready) begin
			n_seen <= n_seen + 1;
			// Early words after power-up are thrown away
			if (n_seen >= 20) begin
				cap_new <= 1'b1;
				cap_word <= {red_data, green_data, blue_data};
			end
		end
	end
endmodule

// *** sim/tao_top_tb_top.sv ***
// Testbench of the triple output pipeline with its capture model
`timescale 1ns/1ps
module tao_top_tb_top;
	// ****************
	// Stimulus and DUT
	// ****************
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic format_select = 1'b0;
	logic signed [9:0] raw = 10'sh000;
	logic stall_en = 1'b0;
	logic [7:0] red_data, green_data, blue_data;
	logic data_valid, clk_out, recv_ready, cap_new;
	logic [23:0] cap_word;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	// Even duty cycle on the sample clock
	always #20 sys_clk = ~sys_clk;
	tao_top i_tao_top (.sys_clk(sys_clk), .resetn(resetn), .format_select(format_select),
		.raw_red(raw), .raw_green(raw - 10'sh010), .raw_blue(raw + 10'sh020),
		.red_data(red_data), .green_data(green_data), .blue_data(blue_data),
		.data_valid(data_valid), .clk_out(clk_out), .recv_ready(recv_ready));
	tao_cap i_tao_cap (.clk(sys_clk), .stall_en(stall_en), .red_data(red_data),
		.green_data(green_data), .blue_data(blue_data), .data_valid(data_valid),
		.recv_ready(recv_ready), .cap_new(cap_new), .cap_word(cap_word));
	// Clip, then flip the top bit for the signed format
	function automatic logic [7:0] fmt(input logic signed [9:0] v, input logic f);
		logic [7:0] c;
		c = (v < 0) ? 8'h00 : ((v > 10'sh0ff) ? 8'hff : v[7:0]);
		return f ? {~c[7], c[6:0]} : c;
	endfunction
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// Inputs move and outputs are read 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			conclude();
		end
	end
	// ****************
	// Scenarios
	// ****************
	task automatic do_reset();
		resetn = 1'b0;
		tick(12);
		resetn = 1'b1;
		tick(19);
		chk(data_valid === 1'b0, "valid during init");
		tick(12);
		chk(data_valid === 1'b1, "no valid after init");
		$display("test reset done");
	endtask
	task automatic t_codes();
		logic signed [9:0] vals [6] = '{-10'sh005, 10'sh000, 10'sh07f, 10'sh080, 10'sh0ff,
			10'sh130};
		for (int f = 0; f < 2; f++) begin
			foreach (vals[i]) begin
				format_select = f[0];
				raw = vals[i];
				tick(12);
				chk(red_data === fmt(raw, f[0]), "red code");
				chk(green_data === fmt(raw - 10'sh010, f[0]), "green code");
				chk(blue_data === fmt(raw + 10'sh020, f[0]), "blue code");
			end
		end
		$display("test codes done");
	endtask
	task automatic t_latency();
		int n;
		format_select = 1'b0;
		raw = 10'sh011;
		tick(12);
		raw = 10'sh044;
		@(negedge sys_clk);
		n = 0;
		while (red_data !== 8'h44 && n < 20) begin
			tick(1);
			n++;
		end
		chk(n == 7, "latency");
		chk(green_data === 8'h34 && blue_data === 8'h64, "channels apart");
		$display("test latency done");
	endtask
	task automatic t_ramp();
		logic [7:0] prev;
		logic ck;
		raw = 10'sh000;
		tick(12);
		for (int i = 1; i < 40; i++) begin
			prev = red_data;
			ck = clk_out;
			raw = 10'(i);
			tick(1);
			if (i > 8) chk(red_data === prev + 8'h01, "gap in stream");
			chk({ck, clk_out} === 2'b01 || {ck, clk_out} === 2'b10, "clock out stuck");
		end
		$display("test ramp done");
	endtask
	task automatic t_stall();
		logic [7:0] last;
		logic [23:0] held;
		logic rdy;
		last = 8'h00;
		stall_en = 1'b1;
		for (int i = 40; i < 120; i++) begin
			held = {red_data, green_data, blue_data};
			rdy = recv_ready;
			raw = 10'(i);
			tick(1);
			if (rdy !== 1'b1) chk({red_data, green_data, blue_data} === held, "moved");
			if (cap_new === 1'b1) begin
				chk(cap_word[23:16] > last, "capture order");
				chk(cap_word[15:0] === {cap_word[23:16] - 8'h10, cap_word[23:16] + 8'h20},
					"unit split");
				last = cap_word[23:16];
			end
		end
		stall_en = 1'b0;
		tick(10);
		chk(last > 8'h40, "too few captures");
		$display("test stall done");
	endtask
	initial begin
		do_reset();
		t_codes();
		t_latency();
		t_ramp();
		t_stall();
		do_reset();
		conclude();
	end
endmodule
